// *** src/pot_device.sv ***
// Device end: serial command decoder with wiper and persistent registers
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
module pot_device #(
   parameter int STORE_CYCLES = pot_pkg::STORE_CYCLES
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   pot_link_if.device        link,
   output logic       [7:0]  wiper_a_o,
   output logic       [7:0]  wiper_b_o,
   output logic       [7:0]  stored_a_o,
   output logic       [7:0]  stored_b_o,
   output logic              ready_o,
   output logic              store_busy_o,
   output logic              standby_o,
   output logic              discard_o
);
   localparam int BUSY_W = $clog2(STORE_CYCLES + 1);
   localparam int INIT_W = $clog2(pot_pkg::INIT_CYCLES + 1);
   localparam int CW = pot_pkg::CNT_W;
   localparam logic [CW-1:0] CNT_MAX  = CW'(pot_pkg::LONG_BITS + 1);
   localparam logic [CW-1:0] CNT_LONG = CW'(pot_pkg::LONG_BITS);
   localparam logic [CW-1:0] CNT_SHRT = CW'(pot_pkg::SHORT_BITS);

   // Refuse a busy time the counter cannot hold
   if (STORE_CYCLES < 1) begin : g_bad_store
      $error("STORE_CYCLES must be at least one");
   end

   typedef enum logic {ST_INIT, ST_RUN} dev_state_t;

   // Link clock domain
   logic [pot_pkg::LONG_BITS-1:0] shift;
   logic [pot_pkg::CNT_W-1:0]     bit_cnt;
   logic                          seen_tog;
   // Chip select edge domain
   logic [pot_pkg::LONG_BITS-1:0] cap_word;
   logic [pot_pkg::CNT_W-1:0]     cap_cnt;
   logic                          frame_tog;
   logic                          epoch_tog;
   // An empty frame leaves the epoch alone, so a stale count is never replayed
   wire                           clocked = (seen_tog == epoch_tog);
   // System clock domain
   logic                          frame_sync;
   logic                          frame_done;
   logic                          cs_sync;
   dev_state_t                    state;
   logic [INIT_W-1:0]             init_cnt;
   logic [BUSY_W-1:0]             busy_cnt;
   logic [7:0]                    wiper  [2];
   logic [7:0]                    stored [2];

   // Shift on each rising serial clock while selected. A new frame is known
   // by an unanswered epoch toggle; that toggle settled at least one
   // chip-select-high time before this edge, so it is read directly.
   always_ff @(posedge link.sclk or posedge rst_i) begin
      if (rst_i) begin
         shift    <= 16'h0000;
         bit_cnt  <= 5'h00;
         seen_tog <= 1'b0;
      end else if (!link.cs_n) begin
         shift <= {shift[pot_pkg::LONG_BITS-2:0], link.din};
         if (seen_tog != epoch_tog) begin
            bit_cnt  <= 5'h01;
            seen_tog <= epoch_tog;
         end else if (bit_cnt != CNT_MAX) begin
            bit_cnt <= bit_cnt + 5'h01;
         end
      end
   end

   // Freeze the frame on the chip select rise; the serial clock is stopped
   // by then, so the copy stays stable until the next rise.
   always_ff @(posedge link.cs_n or posedge rst_i) begin
      if (rst_i) begin
         cap_word  <= 16'h0000;
         cap_cnt   <= 5'h00;
         frame_tog <= 1'b0;
         epoch_tog <= 1'b0;
      end else begin
         cap_word  <= shift;
         cap_cnt   <= clocked ? bit_cnt : 5'h00;
         frame_tog <= ~frame_tog;
         epoch_tog <= epoch_tog ^ clocked;
      end
   end

   // Bring the frame event and the select level into the system clock
   pot_sync u_frame_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (frame_tog),
      .sync_o  (frame_sync)
   );

   pot_sync u_cs_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (link.cs_n),
      .sync_o  (cs_sync)
   );

   // Field extraction for long and short frames
   wire       is_long   = (cap_cnt == CNT_LONG);
   wire       is_short  = (cap_cnt == CNT_SHRT);
   wire [1:0] long_cmd  = cap_word[pot_pkg::LONG_CMD_LSB +: 2];
   wire [1:0] short_cmd = cap_word[pot_pkg::SHORT_CMD_LSB +: 2];
   wire [1:0] cmd_bits  = is_long ? long_cmd : short_cmd;
   wire [1:0] sel_bits  = is_long ? cap_word[pot_pkg::LONG_SEL_LSB +: 2]
                                  : cap_word[pot_pkg::SHORT_SEL_LSB +: 2];
   wire [7:0] code      = cap_word[pot_pkg::CODE_W-1:0];
   wire       pad_long  = (cap_word[pot_pkg::LONG_PAD_HI_LSB +: 2] == 2'h0) &&
                          (cap_word[pot_pkg::LONG_PAD_LO_LSB +: 2] == 2'h0);
   wire       pad_short = (cap_word[pot_pkg::SHORT_PAD_HI_LSB +: 2] == 2'h0) &&
                          (cap_word[pot_pkg::SHORT_PAD_LO_LSB +: 2] == 2'h0);

   // Frame acceptance; anything else is dropped untouched
   wire is_copy   = cmd_bits[1];
   wire is_store  = (cmd_bits == pot_pkg::CMD_WRITE_STORE) ||
                    (cmd_bits == pot_pkg::CMD_COPY_TO_STORE);
   wire pad_ok    = is_long ? pad_long : pad_short;
   wire len_ok    = is_long || (is_short && is_copy);
   wire sel_ok    = (sel_bits != pot_pkg::SEL_NONE) &&
                    (is_copy || sel_bits != pot_pkg::SEL_BOTH);
   wire frame_new = (frame_sync != frame_done);
   wire busy      = (busy_cnt != '0);
   wire accept    = frame_new && (state == ST_RUN) && len_ok && pad_ok &&
                    sel_ok && !(is_store && busy);
   wire init_end  = (state == ST_INIT) && (init_cnt == '0);

   // Which channel a select addresses; bit 0 is A, bit 1 is B
   function automatic logic sel_hit(input logic [1:0] sel, input int ch);
      sel_hit = sel[ch];
   endfunction : sel_hit

   // Power-up sequencing and frame bookkeeping
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state      <= ST_INIT;
         init_cnt   <= INIT_W'(pot_pkg::INIT_CYCLES - 1);
         frame_done <= 1'b0;
         discard_o  <= 1'b0;
      end else begin
         frame_done <= frame_sync;
         discard_o  <= frame_new && !accept;
         case (state)
            ST_INIT: begin
               init_cnt <= init_cnt - INIT_W'(1);
               if (init_cnt == '0) begin
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               state <= ST_RUN;
            end
            default: begin
               state <= ST_INIT;
            end
         endcase
      end
   end

   // Store busy window after any persistent write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_cnt <= '0;
      end else if (accept && is_store) begin
         busy_cnt <= BUSY_W'(STORE_CYCLES);
      end else if (busy) begin
         busy_cnt <= busy_cnt - BUSY_W'(1);
      end
   end

   // One wiper and one persistent register per channel
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      wire hit = accept && sel_hit(sel_bits, ch);
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            wiper[ch]  <= 8'h00;
            stored[ch] <= pot_pkg::MIDSCALE;
         end else if (init_end) begin
            wiper[ch] <= stored[ch];
         end else if (hit) begin
            case (cmd_bits)
               pot_pkg::CMD_WRITE_WIPER:   wiper[ch]  <= code;
               pot_pkg::CMD_WRITE_STORE:   stored[ch] <= code;
               pot_pkg::CMD_COPY_TO_STORE: stored[ch] <= wiper[ch];
               default:                    wiper[ch]  <= stored[ch];
            endcase
         end
      end
   end

   // Register views for the analog side; nothing goes back on the link
   assign wiper_a_o    = wiper[0];
   assign wiper_b_o    = wiper[1];
   assign stored_a_o   = stored[0];
   assign stored_b_o   = stored[1];
   assign ready_o      = (state == ST_RUN);
   assign store_busy_o = busy;
   // Standby whenever ready, chip select is high and no store is in flight
   assign standby_o    = ready_o && cs_sync && !busy;

endmodule : pot_device

// *** src/pot_pkg.sv ***
// Shared constants for the dual potentiometer serial command port
package pot_pkg;

   // System clock rate
   localparam int CLK_MHZ = 100;

   // Power-up reload must complete inside this time (longest, rounded down)
   localparam int INIT_TIME_NS  = 5000;
   localparam int INIT_CYCLES   = (INIT_TIME_NS * CLK_MHZ) / 1000;

   // Persistent store busy time (device) and host guard time
   localparam int STORE_TIME_MS = 12;
   localparam int STORE_CYCLES  = STORE_TIME_MS * CLK_MHZ * 1000;

   // Serial clock half period and chip select high time (least, rounded up)
   localparam int SCLK_HALF_NS      = 100;
   localparam int SCLK_HALF_CYCLES  = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int CS_HIGH_NS        = 200;
   localparam int CS_HIGH_CYCLES    = (CS_HIGH_NS * CLK_MHZ + 999) / 1000;

   // Frame geometry
   localparam int LONG_BITS  = 16;
   localparam int SHORT_BITS = 8;
   localparam int CODE_W     = 8;
   localparam int CNT_W      = 5;

   // Field positions inside a captured long frame and a short frame
   localparam int LONG_PAD_HI_LSB  = 14;
   localparam int LONG_CMD_LSB     = 12;
   localparam int LONG_PAD_LO_LSB  = 10;
   localparam int LONG_SEL_LSB     = 8;
   localparam int SHORT_PAD_HI_LSB = 6;
   localparam int SHORT_CMD_LSB    = 4;
   localparam int SHORT_PAD_LO_LSB = 2;
   localparam int SHORT_SEL_LSB    = 0;

   // Commands carried by command_bit_high/command_bit_low
   typedef enum logic [1:0] {
      CMD_WRITE_WIPER = 2'h0,
      CMD_WRITE_STORE = 2'h1,
      CMD_COPY_TO_STORE = 2'h2,
      CMD_COPY_TO_WIPER = 2'h3
   } cmd_t;

   // Potentiometer selects carried by pot_select_high/pot_select_low
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_BOTH = 2'h3;

   // Persistent register contents as delivered
   localparam logic [7:0] MIDSCALE = 8'h80;

   // Host register map (byte addresses) and field layout
   localparam logic [3:0] REG_FRAME  = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam int FR_CMD_LSB   = 0;
   localparam int FR_SEL_LSB   = 2;
   localparam int FR_CODE_LSB  = 4;
   localparam int FR_SHORT_BIT = 12;
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_WAIT_BIT  = 1;

endpackage : pot_pkg

// *** src/pot_link_if.sv ***
// Three-wire write-only link between the host and the potentiometer
`timescale 1ns/1ps
interface pot_link_if;
   logic cs_n;
   logic sclk;
   logic din;

   modport device (
      input cs_n,
      input sclk,
      input din
   );

   modport host (
      output cs_n,
      output sclk,
      output din
   );
endinterface : pot_link_if

// *** src/pot_sync.sv ***
// Two flip-flop level synchroniser into the system clock domain
`timescale 1ns/1ps
module pot_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta;

   // First stage is read only by the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta   <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule : pot_sync

// *** src/pot_host.sv ***
// Host end: Wishbone-controlled serial master that sends potentiometer frames
`timescale 1ns/1ps
module pot_host #(
   parameter int STORE_CYCLES = pot_pkg::STORE_CYCLES,
   parameter int HALF_CYCLES  = pot_pkg::SCLK_HALF_CYCLES
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic  [3:0]  wb_adr_i,
   input  wire logic  [3:0]  wb_sel_i,
   input  wire logic  [31:0] wb_dat_i,
   output logic       [31:0] wb_dat_o,
   output logic              wb_ack_o,
   pot_link_if.host          link
);
   localparam int GUARD_W = $clog2(STORE_CYCLES + 1);
   localparam int TIM_W   = 8;
   localparam int FR_W    = pot_pkg::FR_SHORT_BIT + 1;

   // Refuse clock timing the link cannot meet or the timer cannot hold
   if (HALF_CYCLES < pot_pkg::SCLK_HALF_CYCLES || HALF_CYCLES > 255) begin : g_bad_half
      $error("HALF_CYCLES out of range");
   end
   if (STORE_CYCLES < 1) begin : g_bad_store
      $error("STORE_CYCLES must be at least one");
   end

   typedef enum logic [2:0] {H_IDLE, H_WAIT, H_LOW, H_HIGH, H_GAP} host_state_t;

   host_state_t                   state;
   logic [FR_W-1:0]               frame;
   logic [pot_pkg::LONG_BITS-1:0] tx;
   logic [pot_pkg::CNT_W-1:0]     bits_left;
   logic [TIM_W-1:0]              tim;
   logic [GUARD_W-1:0]            guard;
   logic                          store_sent;

   // Bus decode; a frame is taken only while the host is idle
   wire bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire hit_frame = (wb_adr_i == pot_pkg::REG_FRAME);
   wire hit_stat  = (wb_adr_i == pot_pkg::REG_STATUS);
   wire start     = bus_req && wb_we_i && hit_frame && (wb_sel_i[1:0] == 2'h3) &&
                    (state == H_IDLE);
   wire [1:0] f_cmd  = wb_dat_i[pot_pkg::FR_CMD_LSB +: 2];
   wire [1:0] f_sel  = wb_dat_i[pot_pkg::FR_SEL_LSB +: 2];
   wire [7:0] f_code = wb_dat_i[pot_pkg::FR_CODE_LSB +: pot_pkg::CODE_W];
   wire       f_shrt = wb_dat_i[pot_pkg::FR_SHORT_BIT];
   wire       f_store = (f_cmd == pot_pkg::CMD_WRITE_STORE) ||
                        (f_cmd == pot_pkg::CMD_COPY_TO_STORE);
   // Long frame puts zeros, command, zeros, select, code; short is the top byte
   wire [15:0] f_word = {2'h0, f_cmd, 2'h0, f_sel, f_shrt ? 8'h00 : f_code};
   wire        busy   = (state != H_IDLE);
   wire        guard_on = (guard != '0);
   wire [31:0] status = {30'h0, guard_on, busy};

   // Single-cycle registered answer; unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i) begin
            if (hit_frame) begin
               wb_dat_o <= {19'h0, frame};
            end else if (hit_stat) begin
               wb_dat_o <= status;
            end else begin
               wb_dat_o <= 32'h0000_0000;
            end
         end
      end
   end

   // Guard between stores so the device can finish writing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         guard <= '0;
      end else if (state == H_LOW && tim == '0 && bits_left == '0 && store_sent) begin
         guard <= GUARD_W'(STORE_CYCLES);
      end else if (guard_on) begin
         guard <= guard - GUARD_W'(1);
      end
   end

   // Frame sequencer; the serial clock is divided from the system clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state      <= H_IDLE;
         frame      <= '0;
         tx         <= 16'h0000;
         bits_left  <= 5'h00;
         tim        <= 8'h00;
         store_sent <= 1'b0;
         link.cs_n  <= 1'b1;
         link.sclk  <= 1'b0;
         link.din   <= 1'b0;
      end else begin
         case (state)
            H_IDLE: begin
               if (start) begin
                  frame      <= wb_dat_i[FR_W-1:0];
                  tx         <= f_shrt ? {f_word[15:8], 8'h00} : f_word;
                  bits_left  <= f_shrt ? 5'(pot_pkg::SHORT_BITS)
                                       : 5'(pot_pkg::LONG_BITS);
                  store_sent <= f_store;
                  state      <= (f_store && guard_on) ? H_WAIT : H_LOW;
                  tim        <= TIM_W'(HALF_CYCLES - 1);
                  link.cs_n  <= (f_store && guard_on);
                  link.din   <= f_word[15];
               end
            end
            H_WAIT: begin
               if (!guard_on) begin
                  state     <= H_LOW;
                  link.cs_n <= 1'b0;
               end
            end
            H_LOW: begin
               if (tim != '0) begin
                  tim <= tim - TIM_W'(1);
               end else if (bits_left == '0) begin
                  link.cs_n <= 1'b1;
                  tim       <= TIM_W'(pot_pkg::CS_HIGH_CYCLES - 1);
                  state     <= H_GAP;
               end else begin
                  link.sclk <= 1'b1;
                  tim       <= TIM_W'(HALF_CYCLES - 1);
                  state     <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (tim != '0) begin
                  tim <= tim - TIM_W'(1);
               end else begin
                  link.sclk <= 1'b0;
                  link.din  <= tx[14];
                  tx        <= {tx[14:0], 1'b0};
                  bits_left <= bits_left - 5'h01;
                  tim       <= TIM_W'(HALF_CYCLES - 1);
                  state     <= H_LOW;
               end
            end
            H_GAP: begin
               if (tim != '0) begin
                  tim <= tim - TIM_W'(1);
               end else begin
                  state <= H_IDLE;
               end
            end
            default: begin
               state <= H_IDLE;
            end
         endcase
      end
   end
endmodule : pot_host

// *** bench/pot_checker.sv ***
// Checker on the potentiometer link and the device outputs
`timescale 1ns/1ps
module pot_checker #(
   parameter int STORE_CYCLES = pot_pkg::STORE_CYCLES,
   parameter int HALF_CYCLES  = pot_pkg::SCLK_HALF_CYCLES
) (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       cs_n,
   input wire logic       sclk,
   input wire logic       din,
   input wire logic [7:0] wiper_a_o,
   input wire logic [7:0] wiper_b_o,
   input wire logic [7:0] stored_a_o,
   input wire logic [7:0] stored_b_o,
   input wire logic       ready_o,
   input wire logic       store_busy_o,
   input wire logic       standby_o
);
   logic        sclk_q;
   logic [7:0]  hi_cnt;
   logic [4:0]  rise_cnt;
   logic [7:0]  gap_cnt;
   logic [20:0] busy_cnt;
   logic [9:0]  init_cnt;
   wire  [31:0] regs = {wiper_a_o, wiper_b_o, stored_a_o, stored_b_o};

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Helper counts; the gap count saturates so long idle spells stay legal
   always_ff @(posedge clk_i) begin
      sclk_q   <= sclk;
      hi_cnt   <= sclk ? hi_cnt + 8'h01 : 8'h00;
      rise_cnt <= cs_n ? 5'h00 : rise_cnt + 5'(sclk && !sclk_q);
      gap_cnt  <= (rst_i || !cs_n) ? 8'h00 : gap_cnt + 8'(gap_cnt != 8'hFF);
      busy_cnt <= store_busy_o ? busy_cnt + 21'h000001 : 21'h000000;
      init_cnt <= rst_i ? 10'h000 : init_cnt + 10'(init_cnt != 10'h3FF);
   end

   sequence frame_end_s;
      $rose(cs_n);
   endsequence
   sequence cs_held_s;
      !cs_n [*4];
   endsequence
   sequence idle_held_s;
      cs_n [*4] ##0 (ready_o && !store_busy_o);
   endsequence

   sclk_idle_a: assert property (cs_n |-> !sclk)
      else $error("serial clock high outside a frame");
   sclk_high_a: assert property ($fell(sclk) |-> hi_cnt == 8'(HALF_CYCLES))
      else $error("serial clock high time wrong");
   din_steady_a: assert property (sclk && $past(sclk) |-> $stable(din))
      else $error("data moved while clock high");
   frame_count_a: assert property (frame_end_s |-> rise_cnt == 5'h10 || rise_cnt == 5'h08)
      else $error("frame clock count wrong");
   pad_zero_a: assert property ($rose(sclk) && !cs_n
      && (rise_cnt[4:1] == 4'h0 || rise_cnt[4:1] == 4'h2) |-> !din)
      else $error("pad bit not zero");
   cs_gap_a: assert property ($fell(cs_n) |-> gap_cnt >= 8'h14)
      else $error("chip select gap too short");
   active_standby_a: assert property (cs_held_s |-> !standby_o)
      else $error("standby during a frame");
   idle_standby_a: assert property (idle_held_s |-> standby_o)
      else $error("no standby while idle");
   ready_match_a: assert property ($rose(ready_o) |-> regs[31:16] == regs[15:0])
      else $error("wipers not reloaded at ready");
   ready_time_a: assert property ($rose(ready_o) |-> init_cnt <= 10'(pot_pkg::INIT_CYCLES + 1))
      else $error("power-up reload too slow");
   busy_bound_a: assert property ($fell(store_busy_o) |-> busy_cnt <= 21'(STORE_CYCLES))
      else $error("store busy too long");
   reg_after_cs_a: assert property ($changed(regs) && $past(ready_o) |-> $past(cs_n, 3))
      else $error("register moved without frame end");
endmodule : pot_checker

// *** bench/dual_pot_serial_cmd_port_tb_top.sv ***
// Self-checking bench joining host and device over the serial link
`timescale 1ns/1ps
module dual_pot_serial_cmd_port_tb_top;
   localparam int SC = 200;
   logic        clk_i;
   logic        rst_i;
   logic        cyc, stb, we, ack, rdy, busy, stby, disc, disc2;
   logic [3:0]  adr, sel;
   logic [31:0] wdat, rdat, q;
   logic [7:0]  wa, wb, sa, sb, w2a, w2b, s2a, s2b, ewa, ewb, esa, esb;
   int          err_count = 0;
   int          cmp_count = 0;
   int          n_disc = 0;
   int          n_disc2 = 0;

   pot_link_if link ();
   pot_link_if link2 ();

   // Host faces device; a second device takes hand-made frames, one good and four faulty
   pot_host #(.STORE_CYCLES(SC)) pot_host_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .link(link.host));
   pot_device #(.STORE_CYCLES(SC)) pot_device_i (
      .clk_i(clk_i), .rst_i(rst_i), .link(link.device), .wiper_a_o(wa), .wiper_b_o(wb),
      .stored_a_o(sa), .stored_b_o(sb), .ready_o(rdy), .store_busy_o(busy),
      .standby_o(stby), .discard_o(disc));
   pot_device #(.STORE_CYCLES(SC)) pot_device_fault_i (
      .clk_i(clk_i), .rst_i(rst_i), .link(link2.device), .wiper_a_o(w2a), .wiper_b_o(w2b),
      .stored_a_o(s2a), .stored_b_o(s2b), .ready_o(), .store_busy_o(),
      .standby_o(), .discard_o(disc2));
   pot_checker #(.STORE_CYCLES(SC), .HALF_CYCLES(pot_pkg::SCLK_HALF_CYCLES)) pot_checker_i (
      .clk_i(clk_i), .rst_i(rst_i), .cs_n(link.cs_n), .sclk(link.sclk), .din(link.din),
      .wiper_a_o(wa), .wiper_b_o(wb), .stored_a_o(sa), .stored_b_o(sb), .ready_o(rdy),
      .store_busy_o(busy), .standby_o(stby));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Rejected frames show only as one-cycle pulses, so count them here
   always @(posedge clk_i) begin
      if (disc === 1'b1) n_disc++;
      if (disc2 === 1'b1) n_disc2++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude();
      $display("Compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude

   // A wait that ran out ends the run at once
   task automatic hang(input logic ok);
      if (!ok) begin
         err_count++;
         $display("[ERR] %0t wait ran out got %h exp %h", $time, ok, 1'b1);
         conclude();
      end
   endtask : hang

   task automatic wb_io(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      hang(ack === 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb_io

   // Poll until the host is idle, then let the device decode the frame
   task automatic host_idle();
      int n;
      n = 0;
      do begin
         wb_io(1'b0, pot_pkg::REG_STATUS, 32'h00000000);
         n++;
      end while (q[pot_pkg::ST_BUSY_BIT] !== 1'b0 && n < 500);
      hang(q[pot_pkg::ST_BUSY_BIT] === 1'b0);
      repeat (6) @(posedge clk_i);
   endtask : host_idle

   // Send one frame through the host and judge the device against a model
   task automatic frame(input logic [1:0] c, input logic [1:0] s, input logic [7:0] d,
                        input logic sh);
      logic ok;
      int   nd;
      ok = s != 2'h0 && !(c[1] == 1'b0 && (s == 2'h3 || sh));
      nd = n_disc;
      wb_io(1'b1, pot_pkg::REG_FRAME, {19'h00000, sh, d, s, c});
      host_idle();
      if (ok && c == 2'h0 && s[0]) ewa = d;
      if (ok && c == 2'h0 && s[1]) ewb = d;
      if (ok && c == 2'h1 && s[0]) esa = d;
      if (ok && c == 2'h1 && s[1]) esb = d;
      if (ok && c == 2'h2 && s[0]) esa = ewa;
      if (ok && c == 2'h2 && s[1]) esb = ewb;
      if (ok && c == 2'h3 && s[0]) ewa = esa;
      if (ok && c == 2'h3 && s[1]) ewb = esb;
      chk({wa, wb, sa, sb}, {ewa, ewb, esa, esb});
      chk(32'(n_disc - nd), {31'h00000000, !ok});
   endtask : frame

   // Hand-driven frame on the second link; data inverts once released
   task automatic raw(input logic [15:0] bits, input int n);
      @(posedge clk_i);
      link2.cs_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         link2.din <= bits[15 - i];
         repeat (10) @(posedge clk_i);
         link2.sclk <= 1'b1;
         repeat (10) @(posedge clk_i);
         link2.sclk <= 1'b0;
      end
      repeat (10) @(posedge clk_i);
      link2.cs_n <= 1'b1;
      link2.din  <= ~link2.din;
      repeat (30) @(posedge clk_i);
   endtask : raw

   task automatic t_powerup();
      int n;
      n = 0;
      while (rdy !== 1'b1 && n < 600) begin
         @(posedge clk_i);
         n++;
      end
      hang(rdy === 1'b1);
      chk(32'(n <= pot_pkg::INIT_CYCLES + 1), 32'h00000001);
      chk({wa, wb, sa, sb}, {4{pot_pkg::MIDSCALE}});
      repeat (4) @(posedge clk_i);
      chk({31'h00000000, stby}, 32'h00000001);
      {ewa, ewb, esa, esb} = {4{pot_pkg::MIDSCALE}};
      $display("Test powerup done");
   endtask : t_powerup

   task automatic t_writes();
      frame(2'h0, 2'h1, 8'h00, 1'b0);
      frame(2'h0, 2'h2, 8'hFF, 1'b0);
      frame(2'h1, 2'h1, 8'h3C, 1'b0);
      wb_io(1'b0, pot_pkg::REG_STATUS, 32'h00000000);
      chk(q, 32'h00000002);
      chk({31'h00000000, busy}, 32'h00000001);
      frame(2'h1, 2'h2, 8'hC3, 1'b0);
      $display("Test writes done");
   endtask : t_writes

   task automatic t_copies();
      frame(2'h2, 2'h3, 8'h00, 1'b1);
      frame(2'h0, 2'h1, 8'h5A, 1'b0);
      frame(2'h3, 2'h1, 8'hFF, 1'b0);
      frame(2'h0, 2'h2, 8'h77, 1'b0);
      frame(2'h2, 2'h2, 8'hA5, 1'b0);
      frame(2'h0, 2'h1, 8'h22, 1'b0);
      frame(2'h3, 2'h3, 8'h00, 1'b1);
      $display("Test copies done");
   endtask : t_copies

   task automatic t_refusals();
      frame(2'h0, 2'h0, 8'h12, 1'b0);
      frame(2'h0, 2'h3, 8'h34, 1'b0);
      frame(2'h1, 2'h3, 8'h56, 1'b0);
      frame(2'h3, 2'h0, 8'h00, 1'b1);
      frame(2'h0, 2'h1, 8'h78, 1'b1);
      wb_io(1'b0, 4'hC, 32'h00000000);
      chk(q, 32'h00000000);
      sel <= 4'hC;
      wb_io(1'b1, pot_pkg::REG_FRAME, 32'h00000994);
      sel <= 4'hF;
      host_idle();
      wb_io(1'b0, pot_pkg::REG_FRAME, 32'h00000000);
      chk(q, 32'h00001784);
      chk({wa, wb, sa, sb}, {ewa, ewb, esa, esb});
      $display("Test refusals done");
   endtask : t_refusals

   task automatic t_faults();
      int nd;
      nd = n_disc2;
      raw(16'h01A5, 16);
      chk({w2a, w2b, s2a, s2b}, 32'hA5808080);
      raw(16'h02C3, 8);
      raw(16'hC300, 8);
      raw(16'h0166, 12);
      raw(16'h4166, 16);
      chk({w2a, w2b, s2a, s2b}, 32'hA5808080);
      chk(32'(n_disc2 - nd), 32'h00000004);
      $display("Test faults done");
   endtask : t_faults

   initial begin
      {cyc, stb, we, adr, wdat} = '0;
      sel = 4'hF;
      link2.cs_n = 1'b1;
      link2.sclk = 1'b0;
      link2.din = 1'b0;
      rst_i <= 1'b1; // Scheduled so every reset process sees the edge
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_powerup();
      t_writes();
      t_copies();
      t_refusals();
      t_faults();
      conclude();
   end
endmodule : dual_pot_serial_cmd_port_tb_top
